//--- hw/flash_prog_pkg.sv
package flash_prog_pkg;

   // command codes seen on the serial link
   localparam logic [7:0] CMD_CLR_FLAG   = 8'h50;
   localparam logic [7:0] CMD_PP         = 8'h02;
   localparam logic [7:0] CMD_DUAL_FP    = 8'hA2;
   localparam logic [7:0] CMD_XDUAL_FP   = 8'hD2;
   localparam logic [7:0] CMD_QUAD_FP    = 8'h32;
   localparam logic [7:0] CMD_XQUAD_FP   = 8'h38;
   localparam logic [7:0] CMD_PP4        = 8'h12;
   localparam logic [7:0] CMD_QUAD_FP4   = 8'h34;
   localparam logic [7:0] CMD_XQUAD_FP4  = 8'h3E;
   localparam logic [7:0] CMD_WREN       = 8'h06;
   localparam logic [7:0] CMD_WRDI       = 8'h04;
   localparam logic [7:0] CMD_RD_STATUS  = 8'h05;
   localparam logic [7:0] CMD_RD_FLAG    = 8'h70;
   localparam logic [7:0] CMD_ENTER4     = 8'hB7;
   localparam logic [7:0] CMD_EXIT4      = 8'hE9;
   localparam logic [7:0] CMD_SUSPEND    = 8'h75;
   localparam logic [7:0] CMD_RESUME     = 8'h7A;

   // link protocol selection
   localparam logic [1:0] PROTO_EXT      = 2'h0;
   localparam logic [1:0] PROTO_DUAL     = 2'h1;
   localparam logic [1:0] PROTO_QUAD     = 2'h2;

   // phase lengths in bits
   localparam logic [5:0] BITS_BYTE      = 6'h08;
   localparam logic [5:0] BITS_ADDR3     = 6'h18;
   localparam logic [5:0] BITS_ADDR4     = 6'h20;

   // status and flag status bit positions
   localparam int ST_WIP                 = 0;
   localparam int ST_WEL                 = 1;
   localparam int FL_ADDR4               = 0;
   localparam int FL_PROT_ERR            = 1;
   localparam int FL_PROG_SUSP           = 2;
   localparam int FL_PROG_ERR            = 4;
   localparam int FL_ERASE_ERR           = 5;
   localparam int FL_READY               = 7;

   // register port map (word index)
   localparam logic [3:0] REG_STATUS     = 4'h0;
   localparam logic [3:0] REG_CFG        = 4'h1;
   localparam logic [3:0] REG_PTR        = 4'h2;
   localparam logic [3:0] REG_ARRAY      = 4'h3;

   // configuration register fields
   localparam int CFG_PROTO_LSB          = 0;
   localparam int CFG_ADDR4_BIT          = 2;
   localparam int CFG_FAIL_BIT           = 3;
   localparam int CFG_PROT_LSB           = 16;

   // timing
   localparam int CLK_PERIOD_NS          = 10;
   localparam int T_PP_NS                = 2000;
   localparam int PP_CYCLES_DEF          = (T_PP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [4:0] {
      FS_CMD  = 5'h01,
      FS_ADDR = 5'h02,
      FS_DATA = 5'h04,
      FS_OUT  = 5'h08,
      FS_SKIP = 5'h10
   } frame_t;

   typedef struct packed {
      logic       sel_n;
      logic       sck;
      logic [3:0] dq;
   } link_in_t;

   typedef struct packed {
      logic [3:0] dq;
      logic [3:0] dq_oe_n;
   } link_out_t;

   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_t;

endpackage : flash_prog_pkg

//--- hw/flash_prog_dev.sv
`timescale 1ns/10ps
// Summary of operation
// - code 50h clears the erase, program and protection error flags.
// - command bits arrive on one, two or four lanes by protocol.
// - raising select at any time ends the clear-flag command.
// - no select rise means no program, no error flags, latch stays set.
// - every address bit is taken on a rising serial clock edge.
// - protected target: skip, keep write enable, set flag bits 1 and 4.
// - a program run with the configuration fail bit set clears write enable and sets program fail.
// - programming only turns ones into zeros.
// - dual-input program is A2h, extended dual-input program is D2h.
// - page program 02h, quad-input 32h, extended quad-input 38h.
// - write-in-progress reads 1 while programming and 0 after.
// - write enable clears at the end of every self-timed program, pass or forced fail.
// - suspend pauses a running program and resume continues it.
// - data past the page end wraps to the page start.
// - more than a page of data keeps only the last page of bytes.
// - a short page leaves the unaddressed bytes of the page untouched.
// - four-byte variants carry a 32-bit address.
// - four-byte codes are 12h, 34h and 3Eh.
// - address length comes from configuration or enter/exit commands.
// - dedicated four-byte commands always take four address bytes.
// - an accepted program runs self-timed without the serial clock.
// - extended protocol takes input on lane 0 and answers on lane 1.
module flash_prog_dev #(
   parameter int PAGE_BYTES    = 256,
   parameter int NUM_PAGES     = 4,
   parameter int PP_CYCLES     = flash_prog_pkg::PP_CYCLES_DEF,
   parameter bit ADDR4_DEFAULT = 1'b0
) (
   input  wire logic                      CORE_CLK_IN,   // core clock, 100 MHz
   input  wire logic                      NRST_IN,       // async reset, active low
   input  wire flash_prog_pkg::link_in_t  LINK_IN,       // select, serial clock, data lanes
   output      flash_prog_pkg::link_out_t LINK_OUT,      // data lanes out and enables
   input  wire flash_prog_pkg::bus_req_t  BUS_REQ_IN,    // register port request
   output      logic [31:0]               BUS_RDATA_OUT  // register read data
);
   import flash_prog_pkg::*;

   localparam int PAGE_W    = $clog2(PAGE_BYTES);
   localparam int PG_W      = (NUM_PAGES > 1) ? $clog2(NUM_PAGES) : 1;
   localparam int MEM_BYTES = PAGE_BYTES * NUM_PAGES;
   localparam int MEM_AW    = PAGE_W + PG_W;
   localparam int TMR_W     = $clog2(PP_CYCLES + 1) + 1;

   generate
      if ((PAGE_BYTES < 2) || ((PAGE_BYTES & (PAGE_BYTES - 1)) != 0)) begin : g_bad_page
         $error("PAGE_BYTES must be a power of two");
      end
      if ((NUM_PAGES < 2) || (NUM_PAGES > 16) || ((NUM_PAGES & (NUM_PAGES - 1)) != 0)) begin : g_bad_pages
         $error("NUM_PAGES must be a power of two from 2 to 16");
      end
      if (PP_CYCLES < 1) begin : g_bad_pp
         $error("PP_CYCLES must be at least one");
      end
   endgenerate

   typedef struct packed {
      link_in_t                          in_s1;
      link_in_t                          in_s2;
      link_in_t                          in_s3;
      frame_t                            fsm;
      logic [31:0]                       shift;
      logic [5:0]                        nbits;
      logic [7:0]                        cmd;
      logic [31:0]                       addr;
      logic [PAGE_W-1:0]                 off;
      logic                              got;
      logic [PAGE_BYTES-1:0][7:0]        pbuf;
      logic [PAGE_BYTES-1:0]             pmask;
      logic [MEM_BYTES-1:0][7:0]         mem;
      logic [PG_W-1:0]                   run_page;
      logic [TMR_W-1:0]                  timer;
      logic                              wel;
      logic                              wip;
      logic                              susp;
      logic                              addr4;
      logic                              prog_err;
      logic                              prot_err;
      logic                              erase_err;
      logic [1:0]                        proto;
      logic                              force_fail;
      logic [NUM_PAGES-1:0]              prot;
      logic [7:0]                        out_sh;
      logic [3:0]                        dq_o;
      logic [3:0]                        dq_oe_n;
      logic [MEM_AW-1:0]                 ptr;
      logic [31:0]                       rdata;
   } state_t;

   state_t st_reg;
   state_t st_next;

   logic       sel_fall;
   logic       sel_rise;
   logic       sck_rise;
   logic       sck_fall;
   logic [7:0] status_byte;
   logic [7:0] flag_byte;

   function automatic logic [2:0] proto_lanes(input logic [1:0] p);
      unique case (p)
         PROTO_DUAL: proto_lanes = 3'h2;
         PROTO_QUAD: proto_lanes = 3'h4;
         default:    proto_lanes = 3'h1;
      endcase
   endfunction : proto_lanes

   // extended protocol widens some phases; dual and quad keep the protocol width
   function automatic logic [2:0] phase_lanes(input logic [1:0] p, input logic [7:0] c, input logic data);
      logic [2:0] w;
      w = proto_lanes(p);
      if (p == PROTO_EXT) begin
         if ((c == CMD_XDUAL_FP) || (data && (c == CMD_DUAL_FP))) begin
            w = 3'h2;
         end else if ((c == CMD_XQUAD_FP) || (c == CMD_XQUAD_FP4) ||
                      (data && ((c == CMD_QUAD_FP) || (c == CMD_QUAD_FP4)))) begin
            w = 3'h4;
         end
      end
      phase_lanes = w;
   endfunction : phase_lanes

   function automatic logic is_prog(input logic [1:0] p, input logic [7:0] c);
      logic dual_c;
      logic quad_c;
      dual_c  = (c == CMD_DUAL_FP) || (c == CMD_XDUAL_FP);
      quad_c  = (c == CMD_QUAD_FP) || (c == CMD_XQUAD_FP) || (c == CMD_QUAD_FP4) || (c == CMD_XQUAD_FP4);
      is_prog = (c == CMD_PP) || (c == CMD_PP4) ||
                (dual_c && (p != PROTO_QUAD)) || (quad_c && (p != PROTO_DUAL));
   endfunction : is_prog

   function automatic logic [31:0] shift_in(input logic [31:0] sh, input logic [3:0] dq, input logic [2:0] w);
      unique case (w)
         3'h2:    shift_in = {sh[29:0], dq[1:0]};
         3'h4:    shift_in = {sh[27:0], dq[3:0]};
         default: shift_in = {sh[30:0], dq[0]};
      endcase
   endfunction : shift_in

   // edges come from the second and third stages; the first stage feeds only the second
   assign sel_fall = !st_reg.in_s2.sel_n && st_reg.in_s3.sel_n;
   assign sel_rise = st_reg.in_s2.sel_n && !st_reg.in_s3.sel_n;
   assign sck_rise = st_reg.in_s2.sck && !st_reg.in_s3.sck && !st_reg.in_s2.sel_n;
   assign sck_fall = !st_reg.in_s2.sck && st_reg.in_s3.sck && !st_reg.in_s2.sel_n;

   always_comb begin
      status_byte          = 8'h00;
      status_byte[ST_WIP]  = st_reg.wip;
      status_byte[ST_WEL]  = st_reg.wel;
      flag_byte                = 8'h00;
      flag_byte[FL_READY]      = !st_reg.wip || st_reg.susp;
      flag_byte[FL_ERASE_ERR]  = st_reg.erase_err;
      flag_byte[FL_PROG_ERR]   = st_reg.prog_err;
      flag_byte[FL_PROG_SUSP]  = st_reg.susp;
      flag_byte[FL_PROT_ERR]   = st_reg.prot_err;
      flag_byte[FL_ADDR4]      = st_reg.addr4;
   end

   always_comb begin
      logic [2:0]  w;
      logic [31:0] sh;
      logic [5:0]  nb;
      logic [5:0]  alen;
      w  = 3'h1;
      sh = 32'h0000_0000;
      nb = 6'h00;
      alen = BITS_ADDR3;
      st_next = st_reg;
      st_next.in_s1 = LINK_IN;
      st_next.in_s2 = st_reg.in_s1;
      st_next.in_s3 = st_reg.in_s2;

      // frame handling; the engine below runs after it so its flag sets win over a clear
      if (sel_fall) begin
         st_next.fsm     = FS_CMD;
         st_next.nbits   = 6'h00;
         st_next.shift   = 32'h0000_0000;
         st_next.dq_oe_n = 4'hF;
      end else if (sel_rise) begin
         // a program starts only on a select rise after whole data bytes
         if ((st_reg.fsm == FS_DATA) && (st_reg.nbits == 6'h00) && st_reg.got) begin
            if (st_reg.prot[st_reg.addr[MEM_AW-1:PAGE_W]]) begin
               st_next.prot_err = 1'b1;
               st_next.prog_err = 1'b1;
            end else begin
               st_next.wip      = 1'b1;
               st_next.timer    = TMR_W'(PP_CYCLES);
               st_next.run_page = st_reg.addr[MEM_AW-1:PAGE_W];
            end
         end
         st_next.fsm     = FS_SKIP;
         st_next.dq_oe_n = 4'hF;
      end else if (sck_rise) begin
         unique case (st_reg.fsm)
            FS_CMD: begin
               w  = proto_lanes(st_reg.proto);
               sh = shift_in(st_reg.shift, st_reg.in_s2.dq, w);
               nb = st_reg.nbits + {3'h0, w};
               st_next.shift = sh;
               st_next.nbits = nb;
               if (nb == BITS_BYTE) begin
                  st_next.cmd   = sh[7:0];
                  st_next.nbits = 6'h00;
                  st_next.fsm   = FS_SKIP;
                  if (is_prog(st_reg.proto, sh[7:0])) begin
                     // busy, suspended or not write enabled: drop silently
                     if (st_reg.wel && !st_reg.wip && !st_reg.susp) begin
                        st_next.fsm = FS_ADDR;
                     end
                  end else begin
                     unique case (sh[7:0])
                        CMD_CLR_FLAG: begin
                           st_next.prog_err  = 1'b0;
                           st_next.prot_err  = 1'b0;
                           st_next.erase_err = 1'b0;
                        end
                        CMD_WREN: begin
                           if (!st_reg.wip) begin
                              st_next.wel = 1'b1;
                           end
                        end
                        CMD_WRDI: begin
                           if (!st_reg.wip) begin
                              st_next.wel = 1'b0;
                           end
                        end
                        CMD_ENTER4: st_next.addr4 = 1'b1;
                        CMD_EXIT4:  st_next.addr4 = 1'b0;
                        CMD_SUSPEND: begin
                           if (st_reg.wip) begin
                              st_next.susp = 1'b1;
                           end
                        end
                        CMD_RESUME: st_next.susp = 1'b0;
                        CMD_RD_STATUS: begin
                           st_next.out_sh = status_byte;
                           st_next.fsm    = FS_OUT;
                        end
                        CMD_RD_FLAG: begin
                           st_next.out_sh = flag_byte;
                           st_next.fsm    = FS_OUT;
                        end
                        default: st_next.fsm = FS_SKIP;
                     endcase
                  end
               end
            end
            FS_ADDR: begin
               w  = phase_lanes(st_reg.proto, st_reg.cmd, 1'b0);
               sh = shift_in(st_reg.shift, st_reg.in_s2.dq, w);
               nb = st_reg.nbits + {3'h0, w};
               st_next.shift = sh;
               st_next.nbits = nb;
               if (st_reg.addr4 || (st_reg.cmd == CMD_PP4) || (st_reg.cmd == CMD_QUAD_FP4) ||
                   (st_reg.cmd == CMD_XQUAD_FP4)) begin
                  alen = BITS_ADDR4;
               end
               if (nb == alen) begin
                  st_next.addr  = (alen == BITS_ADDR4) ? sh : {8'h00, sh[23:0]};
                  st_next.off   = sh[PAGE_W-1:0];
                  st_next.pmask = '0;
                  st_next.got   = 1'b0;
                  st_next.nbits = 6'h00;
                  st_next.fsm   = FS_DATA;
               end
            end
            FS_DATA: begin
               w  = phase_lanes(st_reg.proto, st_reg.cmd, 1'b1);
               sh = shift_in(st_reg.shift, st_reg.in_s2.dq, w);
               nb = st_reg.nbits + {3'h0, w};
               st_next.shift = sh;
               st_next.nbits = nb;
               if (nb == BITS_BYTE) begin
                  // a later byte at the same offset replaces the earlier one
                  st_next.pbuf[st_reg.off]  = sh[7:0];
                  st_next.pmask[st_reg.off] = 1'b1;
                  st_next.off   = st_reg.off + PAGE_W'(1);
                  st_next.got   = 1'b1;
                  st_next.nbits = 6'h00;
               end
            end
            FS_OUT: begin
            end
            FS_SKIP: begin
            end
         endcase
      end else if (sck_fall && (st_reg.fsm == FS_OUT)) begin
         w  = proto_lanes(st_reg.proto);
         nb = st_reg.nbits + {3'h0, w};
         unique case (w)
            3'h2: begin
               st_next.dq_o    = {2'h0, st_reg.out_sh[7:6]};
               st_next.dq_oe_n = 4'hC;
            end
            3'h4: begin
               st_next.dq_o    = st_reg.out_sh[7:4];
               st_next.dq_oe_n = 4'h0;
            end
            default: begin
               st_next.dq_o    = {2'h0, st_reg.out_sh[7], 1'b0};
               st_next.dq_oe_n = 4'hD;
            end
         endcase
         st_next.out_sh = st_reg.out_sh << w;
         st_next.nbits  = nb;
         if (nb == BITS_BYTE) begin
            // the register is re-read for every byte so polling sees fresh progress
            st_next.out_sh = (st_reg.cmd == CMD_RD_FLAG) ? flag_byte : status_byte;
            st_next.nbits  = 6'h00;
         end
      end

      // self-timed program engine, held while suspended
      if (st_reg.wip && !st_reg.susp) begin
         if (st_reg.timer == TMR_W'(1)) begin
            st_next.wip = 1'b0;
            st_next.wel = 1'b0;
            if (st_reg.force_fail) begin
               st_next.prog_err = 1'b1;
            end else begin
               for (int i = 0; i < PAGE_BYTES; i++) begin
                  if (st_reg.pmask[i]) begin
                     st_next.mem[{st_reg.run_page, PAGE_W'(i)}] =
                        st_reg.mem[{st_reg.run_page, PAGE_W'(i)}] & st_reg.pbuf[i];
                  end
               end
            end
         end else begin
            st_next.timer = st_reg.timer - TMR_W'(1);
         end
      end

      // register port: read data valid only in the cycle after the strobe
      st_next.rdata = 32'h0000_0000;
      if (BUS_REQ_IN.rd) begin
         unique case (BUS_REQ_IN.addr)
            REG_STATUS: st_next.rdata = {16'h0000, flag_byte, status_byte};
            REG_CFG: begin
               st_next.rdata[CFG_PROTO_LSB +: 2]         = st_reg.proto;
               st_next.rdata[CFG_ADDR4_BIT]              = st_reg.addr4;
               st_next.rdata[CFG_FAIL_BIT]               = st_reg.force_fail;
               st_next.rdata[CFG_PROT_LSB +: NUM_PAGES]  = st_reg.prot;
            end
            REG_PTR:   st_next.rdata[MEM_AW-1:0] = st_reg.ptr;
            REG_ARRAY: st_next.rdata[7:0]        = st_reg.mem[st_reg.ptr];
            default:   st_next.rdata = 32'h0000_0000;
         endcase
      end
      if (BUS_REQ_IN.wr) begin
         if (BUS_REQ_IN.addr == REG_CFG) begin
            // protocol change mid-frame is the writer's hazard; it is used from the next edge
            st_next.proto      = BUS_REQ_IN.wdata[CFG_PROTO_LSB +: 2];
            st_next.addr4      = BUS_REQ_IN.wdata[CFG_ADDR4_BIT];
            st_next.force_fail = BUS_REQ_IN.wdata[CFG_FAIL_BIT];
            st_next.prot       = BUS_REQ_IN.wdata[CFG_PROT_LSB +: NUM_PAGES];
         end else if (BUS_REQ_IN.addr == REG_PTR) begin
            st_next.ptr = BUS_REQ_IN.wdata[MEM_AW-1:0];
         end
      end
   end

   always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         st_reg         <= '0;
         st_reg.in_s1   <= '1;
         st_reg.in_s2   <= '1;
         st_reg.in_s3   <= '1;
         st_reg.fsm     <= FS_SKIP;
         st_reg.mem     <= '1;
         st_reg.pbuf    <= '1;
         st_reg.dq_oe_n <= 4'hF;
         st_reg.addr4   <= ADDR4_DEFAULT;
         st_reg.proto   <= PROTO_EXT;
      end else begin
         st_reg <= st_next;
      end
   end

   assign LINK_OUT      = '{dq: st_reg.dq_o, dq_oe_n: st_reg.dq_oe_n};
   assign BUS_RDATA_OUT = st_reg.rdata;

endmodule : flash_prog_dev

//--- tb/flash_prog_host.sv
`timescale 1ns/10ps
module flash_prog_host (
   input  wire logic                     clk_in,   // pacing clock
   input  wire logic [3:0]               lanes_in, // device output lanes
   output      flash_prog_pkg::link_in_t link_out  // select, serial clock, lanes
);
   import flash_prog_pkg::*;
   logic [7:0] rx;
   initial link_out = '{sel_n: 1'b1, sck: 1'b0, dq: 4'h5};
   // half of an 80 ns serial clock period
   task automatic half;
      repeat (4) @(posedge clk_in);
   endtask : half
   task automatic start;
      link_out.sel_n <= 1'b0;
      half();
   endtask : start
   // sck stands low between frames; the lanes flip so a stale bit never looks valid
   task automatic stop;
      half();
      link_out.sel_n <= 1'b1;
      link_out.dq    <= ~link_out.dq;
      half();
      half();
   endtask : stop
   task automatic put_byte(input logic [7:0] b, input int n);
      logic [7:0] s;
      s = b;
      for (int i = 0; i < 8; i += n) begin
         link_out.dq <= (n == 4) ? s[7:4] : (n == 2) ? {~s[7:6], s[7:6]} : {~s[7], s[7], ~s[7], s[7]};
         s = s << n;
         half();
         rx = {rx[6:0], lanes_in[1]};
         link_out.sck <= 1'b1;
         half();
         link_out.sck <= 1'b0;
      end
   endtask : put_byte
endmodule : flash_prog_host

//--- tb/flash_prog_dev_assertions.sv
`timescale 1ns/10ps
module flash_prog_dev_assertions (
   input wire logic                      CORE_CLK_IN,   // clock
   input wire logic                      NRST_IN,       // reset
   input wire flash_prog_pkg::link_in_t  LINK_IN,       // link in
   input wire flash_prog_pkg::link_out_t LINK_OUT,      // link out
   input wire flash_prog_pkg::bus_req_t  BUS_REQ_IN,    // bus request
   input wire logic [31:0]               BUS_RDATA_OUT  // read data
);
   import flash_prog_pkg::*;
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (!NRST_IN);
   logic [1:0] proto_reg;
   logic [1:0] proto_next;
   assign proto_next = (BUS_REQ_IN.wr && BUS_REQ_IN.addr == REG_CFG) ? BUS_REQ_IN.wdata[1:0] : proto_reg;
   always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) proto_reg <= PROTO_EXT;
      else proto_reg <= proto_next;
   end
   sequence s_rd(logic [3:0] a);
      BUS_REQ_IN.rd && BUS_REQ_IN.addr == a;
   endsequence
   sequence s_cfg_wr_rd;
      BUS_REQ_IN.wr && BUS_REQ_IN.addr == REG_CFG ##1 s_rd(REG_CFG);
   endsequence
   property p_ready;
      s_rd(REG_STATUS) |=> BUS_RDATA_OUT[8+FL_READY] == (!BUS_RDATA_OUT[ST_WIP] || BUS_RDATA_OUT[8+FL_PROG_SUSP]);
   endproperty
   a_ready: assert property (p_ready) else $error("ready flag wrong");
   property p_wel;
      s_rd(REG_STATUS) |=> !BUS_RDATA_OUT[ST_WIP] || BUS_RDATA_OUT[ST_WEL];
   endproperty
   a_wel: assert property (p_wel) else $error("latch clear while busy");
   property p_prot;
      s_rd(REG_STATUS) |=> !BUS_RDATA_OUT[8+FL_PROT_ERR] || BUS_RDATA_OUT[8+FL_PROG_ERR];
   endproperty
   a_prot: assert property (p_prot) else $error("protect without fail");
   property p_zero;
      s_rd(REG_STATUS) |=> BUS_RDATA_OUT[31:16] == 16'h0 && !BUS_RDATA_OUT[8+FL_ERASE_ERR];
   endproperty
   a_zero: assert property (p_zero) else $error("status spare bits set");
   property p_cfg;
      s_cfg_wr_rd |=> BUS_RDATA_OUT[2:0] == $past(BUS_REQ_IN.wdata[2:0], 2);
   endproperty
   a_cfg: assert property (p_cfg) else $error("config readback wrong");
   property p_ext;
      proto_reg == PROTO_EXT |-> LINK_OUT.dq_oe_n[0] && LINK_OUT.dq_oe_n[3:2] == 2'h3;
   endproperty
   a_ext: assert property (p_ext) else $error("extended lane driven");
   property p_dual;
      proto_reg == PROTO_DUAL |-> LINK_OUT.dq_oe_n[3:2] == 2'h3;
   endproperty
   a_dual: assert property (p_dual) else $error("dual upper lane driven");
   property p_idle;
      LINK_IN.sel_n [*6] |-> LINK_OUT.dq_oe_n == 4'hF;
   endproperty
   a_idle: assert property (p_idle) else $error("lanes driven deselected");
endmodule : flash_prog_dev_assertions
bind flash_prog_dev flash_prog_dev_assertions i_flash_prog_dev_assertions (
   .CORE_CLK_IN, .NRST_IN, .LINK_IN, .LINK_OUT, .BUS_REQ_IN, .BUS_RDATA_OUT
);

//--- tb/test_serial_flash_program_cmds.sv
`timescale 1ns/10ps
module test_serial_flash_program_cmds;
   import flash_prog_pkg::*;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   link_in_t    link;
   link_out_t   lout;
   bus_req_t    req = '0;
   logic [31:0] rdata;
   logic [31:0] got;
   logic [7:0]  mem [64];
   logic [7:0]  sd = 8'h96;
   int          cl = 1;
   int          err_total = 0;
   int          samples_checked = 0;
   // code, address lanes, data lanes, address bytes
   localparam logic [19:0] TAB [8] = '{20'h02113, 20'hA2123, 20'hD2223, 20'h32143,
                                       20'h38443, 20'h12114, 20'h34144, 20'h3E444};
   always #5 clk = ~clk;
   flash_prog_dev #(.PAGE_BYTES(16), .NUM_PAGES(4), .PP_CYCLES(200)) i_flash_prog_dev (.CORE_CLK_IN(clk),
      .NRST_IN(nrst), .LINK_IN(link), .LINK_OUT(lout), .BUS_REQ_IN(req), .BUS_RDATA_OUT(rdata));
   flash_prog_host i_flash_prog_host (.clk_in(clk), .lanes_in(lout.dq), .link_out(link));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
      samples_checked++;
      if (a !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, a);
      end
   endtask : chk
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      req.addr  <= a;
      req.wdata <= d;
      req.wr    <= 1'b1;
      @(posedge clk);
      req.wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [3:0] a);
      req.addr <= a;
      req.rd   <= 1'b1;
      @(posedge clk);
      req.rd <= 1'b0;
      @(posedge clk);
      got = rdata;
   endtask : rd_reg
   task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
      rd_reg(a);
      chk(nm, e, got);
   endtask : rchk
   task automatic cmd1(input logic [7:0] c);
      i_flash_prog_host.start();
      i_flash_prog_host.put_byte(c, cl);
      i_flash_prog_host.put_byte(8'h00, cl);
      i_flash_prog_host.stop();
   endtask : cmd1
   task automatic idle;
      int k;
      k = 0;
      do begin
         rd_reg(REG_STATUS);
         k++;
      end while (got[ST_WIP] !== 1'b0 && k < 400);
      chk("idle", 32'h0, {31'h0, got[ST_WIP]});
   endtask : idle
   task automatic chk_mem;
      for (int j = 0; j < 64; j++) begin
         wr_reg(REG_PTR, 32'(j));
         rchk("array", REG_ARRAY, {24'h0, mem[j]});
      end
   endtask : chk_mem
   task automatic prog(input logic [7:0] c, input int al, input int dl, input int na, input int a, input int nb,
                       input bit ok);
      logic [7:0] pb [16];
      logic [7:0] d;
      foreach (pb[j]) pb[j] = 8'hFF;
      i_flash_prog_host.start();
      i_flash_prog_host.put_byte(c, cl);
      for (int i = na; i > 0; i--) i_flash_prog_host.put_byte(i == 1 ? 8'(a) : 8'h00, al);
      for (int i = 0; i < nb; i++) begin
         d = sd ^ 8'(i * 7);
         pb[(a + i) % 16] = d;
         i_flash_prog_host.put_byte(d, dl);
      end
      i_flash_prog_host.stop();
      sd = sd + 8'h33;
      if (ok) foreach (pb[j]) mem[a / 16 * 16 + j] &= pb[j];
   endtask : prog
   task automatic give_verdict;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      #500_000;
      err_total++;
      give_verdict();
   end
   initial begin
      foreach (mem[j]) mem[j] = 8'hFF;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      rchk("status", REG_STATUS, 32'h8000);
      rchk("unmapped", 4'hF, 32'h0);
      prog(CMD_PP, 1, 1, 3, 0, 1, 0);
      rchk("status", REG_STATUS, 32'h8000);
      foreach (TAB[i]) begin
         cmd1(CMD_WREN);
         rchk("status", REG_STATUS, 32'h8002);
         prog(TAB[i][19:12], int'(TAB[i][11:8]), int'(TAB[i][7:4]), int'(TAB[i][3:0]), i * 8 + 5, 4, 1);
         rchk("status", REG_STATUS, 32'h0003);
         idle();
         rchk("status", REG_STATUS, 32'h8000);
      end
      cmd1(CMD_WREN);
      prog(CMD_PP, 1, 1, 3, 30, 20, 1);
      idle();
      chk_mem();
      wr_reg(REG_CFG, 32'h0004_0000);
      cmd1(CMD_WREN);
      prog(CMD_PP, 1, 1, 3, 40, 1, 0);
      rchk("status", REG_STATUS, 32'h9202);
      cmd1(CMD_CLR_FLAG);
      rchk("status", REG_STATUS, 32'h8002);
      wr_reg(REG_CFG, 32'h8);
      prog(CMD_PP, 1, 1, 3, 0, 2, 0);
      idle();
      rchk("status", REG_STATUS, 32'h9000);
      cmd1(CMD_CLR_FLAG);
      rchk("status", REG_STATUS, 32'h8000);
      wr_reg(REG_CFG, 32'h0);
      cmd1(CMD_WREN);
      prog(CMD_PP, 1, 1, 3, 50, 2, 1);
      cmd1(CMD_SUSPEND);
      repeat (300) @(posedge clk);
      rchk("status", REG_STATUS, 32'h8403);
      cmd1(CMD_RD_FLAG);
      chk("link", 32'h84, {24'h0, i_flash_prog_host.rx});
      cmd1(CMD_RESUME);
      idle();
      rchk("status", REG_STATUS, 32'h8000);
      cmd1(CMD_ENTER4);
      rchk("status", REG_STATUS, 32'h8100);
      cmd1(CMD_WREN);
      prog(CMD_PP, 1, 1, 4, 20, 2, 1);
      idle();
      cmd1(CMD_EXIT4);
      wr_reg(REG_CFG, 32'h1);
      rchk("config", REG_CFG, 32'h1);
      cl = 2;
      cmd1(CMD_WREN);
      prog(CMD_PP, 2, 2, 3, 60, 2, 1);
      idle();
      rchk("status", REG_STATUS, 32'h8000);
      wr_reg(REG_CFG, 32'h0);
      chk_mem();
      give_verdict();
   end
endmodule : test_serial_flash_program_cmds
